/* File: and_bclr_exec.sv */
// and_bclr_exec: executes literal-AND, file-AND and bit-clear words
// assumes data memory answers a read with rdata on the next clock
`timescale 1ns/1ps
module and_bclr_exec (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // instruction fetch
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  // data memory
  input wire logic [7:0] mem_rdata,
  output and_bclr_pkg::mem_req_t mem_req,
  // core state
  output logic [7:0] working_reg,
  output logic zero_flag,
  output logic [1:0] phase,
  output logic done
);
  and_bclr_pkg::qphase_t q_q;
  and_bclr_pkg::op_t op_q;
  and_bclr_pkg::op_t op_dec;
  logic [15:0] word_q;
  logic [7:0] opnd_q;
  logic [7:0] res_q;
  logic [7:0] res_d;
  logic [7:0] working_reg_q;
  logic z_q;
  logic done_q;
  and_bclr_pkg::mem_req_t req_q;

  op_decode u_dec (
    .word(instr),
    .op(op_dec)
  );

  // ==========================================================
  // quarter-phase sequencer; idles in decode until a word arrives
  always_ff @(posedge clk) begin
    if (srst) begin
      q_q <= and_bclr_pkg::q_decode;
    end else begin
      case (q_q)
        and_bclr_pkg::q_decode: if (instr_valid) q_q <= and_bclr_pkg::q_read;
        and_bclr_pkg::q_read: q_q <= and_bclr_pkg::q_execute;
        and_bclr_pkg::q_execute: q_q <= and_bclr_pkg::q_write;
        default: q_q <= and_bclr_pkg::q_decode;
      endcase
    end
  end

  // ==========================================================
  // latch word and class in decode
  always_ff @(posedge clk) begin
    if (srst) begin
      op_q <= and_bclr_pkg::op_none;
      word_q <= 16'h0000;
    end else if (q_q == and_bclr_pkg::q_decode && instr_valid) begin
      op_q <= op_dec;
      word_q <= instr;
    end
  end

  // ==========================================================
  // memory read issued as decode ends, sampled during read phase
  always_ff @(posedge clk) begin
    if (srst) begin
      req_q <= '0;
    end else begin
      req_q.rd <= q_q == and_bclr_pkg::q_decode && instr_valid &&
                  (op_dec == and_bclr_pkg::op_and_file_op || op_dec == and_bclr_pkg::op_bclr);
      req_q.wr <= 1'b0;
      if (q_q == and_bclr_pkg::q_decode && instr_valid) begin
        req_q.addr <= instr[7:0];
      end
      if (q_q == and_bclr_pkg::q_execute) begin
        // register written only in the fourth phase
        req_q.wr <= to_file(op_q, word_q[and_bclr_pkg::dest_bit]);
        req_q.wdata <= res_d;
      end
    end
  end

  // operand fetch: literal or register contents
  always_ff @(posedge clk) begin
    if (srst) begin
      opnd_q <= 8'h00;
    end else if (q_q == and_bclr_pkg::q_read) begin
      opnd_q <= (op_q == and_bclr_pkg::op_and_literal_op) ? word_q[7:0] : mem_rdata;
    end
  end

  // ==========================================================
  // execute: bit-clear mask or AND with the working register
  function automatic logic [7:0] clear_mask(input logic [2:0] pos);
    clear_mask = ~(8'h01 << pos);
  endfunction

  // destination decoding, shared by the memory write strobe and the write-back
  function automatic logic to_file(input and_bclr_pkg::op_t op, input logic d);
    to_file = op == and_bclr_pkg::op_bclr || (op == and_bclr_pkg::op_and_file_op && d);
  endfunction

  function automatic logic to_working_reg(input and_bclr_pkg::op_t op, input logic d);
    to_working_reg = op == and_bclr_pkg::op_and_literal_op || (op == and_bclr_pkg::op_and_file_op && !d);
  endfunction

  // unknown words fall into the AND branch but never reach a destination
  always_comb begin
    if (op_q == and_bclr_pkg::op_bclr) begin
      res_d = opnd_q & clear_mask(word_q[and_bclr_pkg::bitpos_lsb +: 3]);
    end else begin
      res_d = opnd_q & working_reg_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      res_q <= 8'h00;
    end else if (q_q == and_bclr_pkg::q_execute) begin
      res_q <= res_d;
    end
  end

  // ==========================================================
  // write-back of working register and zero flag
  always_ff @(posedge clk) begin
    if (srst) begin
      working_reg_q <= and_bclr_pkg::working_reg_rst;
      z_q <= 1'b0;
    end else if (q_q == and_bclr_pkg::q_write) begin
      if (to_working_reg(op_q, word_q[and_bclr_pkg::dest_bit])) begin
        working_reg_q <= res_q;
      end
      if (op_q == and_bclr_pkg::op_and_literal_op || op_q == and_bclr_pkg::op_and_file_op) begin
        z_q <= (res_q == 8'h00);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= q_q == and_bclr_pkg::q_write;
    end
  end

  assign mem_req = req_q;
  assign working_reg = working_reg_q;
  assign zero_flag = z_q;
  assign phase = q_q;
  assign done = done_q;

  // ==========================================================
  // checks
  sequence s_start;
    q_q == and_bclr_pkg::q_decode && instr_valid;
  endsequence

  sequence s_phases;
    q_q == and_bclr_pkg::q_read ##1 q_q == and_bclr_pkg::q_execute
      ##1 q_q == and_bclr_pkg::q_write ##1 q_q == and_bclr_pkg::q_decode;
  endsequence

  cycle_len_a: assert property (@(posedge clk) disable iff (srst)
    s_start |=> s_phases)
    else $error("instruction cycle not four phases");

  rd_pulse_a: assert property (@(posedge clk) disable iff (srst)
    req_q.rd |=> !req_q.rd)
    else $error("memory read longer than one phase");

  done_pulse_a: assert property (@(posedge clk) disable iff (srst)
    done_q |=> !done_q)
    else $error("done longer than one cycle");

  bclr_read_a: assert property (@(posedge clk) disable iff (srst)
    s_start and op_dec == and_bclr_pkg::op_bclr |=> req_q.rd ##2 req_q.wr)
    else $error("bit clear read or write misplaced");

  literal_and_a: assert property (@(posedge clk) disable iff (srst)
    s_start and op_dec == and_bclr_pkg::op_and_literal_op |=> ##3
      working_reg_q == ($past(instr[7:0], 4) & $past(working_reg_q, 4)))
    else $error("literal and result wrong");

  literal_nowr_a: assert property (@(posedge clk) disable iff (srst)
    s_start and op_dec == and_bclr_pkg::op_and_literal_op |=> !req_q.wr [*4])
    else $error("literal and wrote memory");

  file_dest_a: assert property (@(posedge clk) disable iff (srst)
    s_start and op_dec == and_bclr_pkg::op_and_file_op and instr[8] |=> ##3
      $stable(working_reg_q))
    else $error("file and with d set changed working register");

  file_write_a: assert property (@(posedge clk) disable iff (srst)
    s_start and op_dec == and_bclr_pkg::op_and_file_op and instr[8] |=> ##2
      req_q.wr && req_q.addr == $past(instr[7:0], 3) &&
      req_q.wdata == ($past(mem_rdata, 2) & working_reg_q))
    else $error("file and with d set wrote wrong value");

  file_working_reg_a: assert property (@(posedge clk) disable iff (srst)
    s_start and op_dec == and_bclr_pkg::op_and_file_op and !instr[8] |=> ##3
      working_reg_q == ($past(working_reg_q, 4) & $past(mem_rdata, 3)))
    else $error("file and with d clear gave wrong working register");

  bclr_value_a: assert property (@(posedge clk) disable iff (srst)
    q_q == and_bclr_pkg::q_write && op_q == and_bclr_pkg::op_bclr |->
      req_q.wdata[word_q[10:8]] == 1'b0 && req_q.addr == word_q[7:0])
    else $error("bit clear value wrong");

  // only a set selected bit may differ from what was read
  bclr_keep_a: assert property (@(posedge clk) disable iff (srst)
    q_q == and_bclr_pkg::q_write && op_q == and_bclr_pkg::op_bclr |->
      (req_q.wdata ^ opnd_q) == (opnd_q & (8'h01 << word_q[10:8])))
    else $error("bit clear disturbed other bits");

  bclr_flag_a: assert property (@(posedge clk) disable iff (srst)
    q_q == and_bclr_pkg::q_write && op_q == and_bclr_pkg::op_bclr |=> $stable(z_q))
    else $error("bit clear altered zero flag");

  zero_flag_a: assert property (@(posedge clk) disable iff (srst)
    q_q == and_bclr_pkg::q_write && op_q != and_bclr_pkg::op_bclr &&
      op_q != and_bclr_pkg::op_none |=>
      z_q == (($past(opnd_q) & $past(working_reg_q)) == 8'h00))
    else $error("zero flag wrong");

endmodule

/* File: and_bclr_pkg.sv */
// package: opcode patterns, quarter-phase states and the carrier struct
// assumes one 100 MHz core clock; one quarter phase per rising clock edge
package and_bclr_pkg;

  // ==========================================================
  // opcode fields
  localparam logic [7:0] and_literal_op = 8'hB5;
  localparam logic [6:0] and_file_op = 7'h05;
  localparam logic [4:0] bit_clear_op = 5'h11;
  localparam int dest_bit = 8;
  localparam int bitpos_lsb = 8;
  localparam logic [7:0] working_reg_rst = 8'h00;

  // ==========================================================
  // quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    q_decode,
    q_read,
    q_execute,
    q_write
  } qphase_t;

  typedef enum logic [1:0] {
    op_none,
    op_and_literal_op,
    op_and_file_op,
    op_bclr
  } op_t;

  // data memory request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

endpackage

/* File: op_decode.sv */
// op_decode: classifies one 16-bit instruction word
// assumes the word is stable while the decode phase samples it
`timescale 1ns/1ps
module op_decode (
  // instruction word
  input wire logic [15:0] word,
  // decoded class
  output and_bclr_pkg::op_t op
);
  // ==========================================================
  // decode
  always_comb begin
    if (word[15:8] == and_bclr_pkg::and_literal_op) begin
      op = and_bclr_pkg::op_and_literal_op;
    end else if (word[15:9] == and_bclr_pkg::and_file_op) begin
      op = and_bclr_pkg::op_and_file_op;
    end else if (word[15:11] == and_bclr_pkg::bit_clear_op) begin
      op = and_bclr_pkg::op_bclr;
    end else begin
      op = and_bclr_pkg::op_none;
    end
  end
endmodule

/* File: data_mem_model.sv */
// data_mem_model: 256 byte data memory facing the exec block
// assumes mem_req is registered by the block; one clock domain
`timescale 1ns/1ps
module data_mem_model (
  // clock
  input wire logic clk,
  // memory port
  input wire and_bclr_pkg::mem_req_t mem_req,
  output logic [7:0] mem_rdata,
  // test preload, used only while the block is idle
  input wire logic load,
  input wire logic [7:0] load_addr,
  input wire logic [7:0] load_data
);
  // ==========================================================
  // storage
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  logic hold_q = 1'b0;
  always_ff @(posedge clk) begin
    hold_q <= mem_req.rd;
    if (mem_req.rd) begin
      last_q <= mem[mem_req.addr];
    end
    if (load) begin
      mem[load_addr] <= load_data;
    end
    if (mem_req.wr) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end
  // data held one cycle past the read, then inverted so stale data never matches
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : (hold_q ? last_q : ~last_q);
endmodule

/* File: and_bitclear_instruction_exec_tb_top.sv */
// testbench for and_bclr_exec with a behavioural data memory
// assumes 100 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
module and_bitclear_instruction_exec_tb_top;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic instr_valid = 1'b0;
  logic [7:0] mem_rdata;
  and_bclr_pkg::mem_req_t mem_req;
  logic [7:0] working_reg;
  logic zero_flag;
  logic [1:0] phase;
  logic done;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] rd_at, wr_at, waddr, wdat;
  logic load = 1'b0;
  logic [7:0] load_addr = 8'h00;
  logic [7:0] load_data = 8'h00;

  and_bclr_exec uut (.clk(clk), .srst(srst), .instr(instr), .instr_valid(instr_valid),
    .mem_rdata(mem_rdata), .mem_req(mem_req), .working_reg(working_reg),
    .zero_flag(zero_flag), .phase(phase), .done(done));
  data_mem_model mdl (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .load(load), .load_addr(load_addr), .load_data(load_data));

  initial begin
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic preload(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    load = 1'b1;
    load_addr = a;
    load_data = d;
    @(negedge clk);
    load = 1'b0;
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one instruction; keep holds instr_valid high through phases 1-3
  task automatic run(input logic [15:0] w, input logic keep);
    int n;
    n = 0;
    @(negedge clk);
    while (phase !== 2'h0 && n < 8) begin
      @(negedge clk);
      n++;
    end
    check("idle phase", {6'h00, phase}, 8'h00);
    instr = w;
    instr_valid = 1'b1;
    rd_at = 8'h00;
    wr_at = 8'h00;
    for (int i = 1; i <= 4; i++) begin
      @(negedge clk);
      instr_valid = keep && i < 4;
      if (mem_req.rd === 1'b1) rd_at = 8'(i);
      if (mem_req.wr === 1'b1) begin
        wr_at = 8'(i);
        waddr = mem_req.addr;
        wdat = mem_req.wdata;
      end
      check("phase", {6'h00, phase}, 8'(i % 4));
      check("done", {7'h00, done}, (i == 4) ? 8'h01 : 8'h00);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_bclr(input logic zexp, input logic keep);
    logic [7:0] a;
    for (int b = 0; b < 8; b++) begin
      a = 8'h40 + 8'(b);
      preload(a, 8'hFF);
      run({and_bclr_pkg::bit_clear_op, 3'(b), a}, keep);
      check("bclr rd", rd_at, 8'h01);
      check("bclr wr", wr_at, 8'h03);
      check("bclr addr", waddr, a);
      check("bclr data", wdat, 8'hFF & ~(8'h01 << b));
      check("bclr mem", mdl.mem[a], 8'hFF & ~(8'h01 << b));
      check("bclr zero", {7'h00, zero_flag}, {7'h00, zexp});
    end
  endtask

  task automatic t_and_literal_op;
    logic [7:0] ks [3] = '{8'hFF, 8'h00, 8'h5F};
    foreach (ks[j]) begin
      run({and_bclr_pkg::and_literal_op, ks[j]}, 1'b0);
      check("and_literal_op w", working_reg, 8'h00);
      check("and_literal_op zero", {7'h00, zero_flag}, 8'h01);
      check("and_literal_op wr", wr_at, 8'h00);
    end
  endtask

  task automatic t_and_file_op;
    preload(8'h80, 8'hC2);
    run({and_bclr_pkg::and_file_op, 1'b1, 8'h80}, 1'b0);
    check("andwf1 rd", rd_at, 8'h01);
    check("andwf1 wr", wr_at, 8'h03);
    check("andwf1 data", wdat, 8'h00);
    check("andwf1 mem", mdl.mem[8'h80], 8'h00);
    check("andwf1 zero", {7'h00, zero_flag}, 8'h01);
    preload(8'h81, 8'h17);
    run({and_bclr_pkg::and_file_op, 1'b0, 8'h81}, 1'b0);
    check("andwf0 wr", wr_at, 8'h00);
    check("andwf0 mem", mdl.mem[8'h81], 8'h17);
    check("andwf0 w", working_reg, 8'h00);
  endtask

  // reset in the read phase must cancel the pending register write
  task automatic t_abort;
    preload(8'h90, 8'hFF);
    @(negedge clk);
    instr = {and_bclr_pkg::and_file_op, 1'b1, 8'h90};
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    check("abort phase", {6'h00, phase}, 8'h00);
    check("abort wr", {7'h00, mem_req.wr}, 8'h00);
    repeat (3) @(negedge clk);
    check("abort mem", mdl.mem[8'h90], 8'hFF);
    check("abort idle", {6'h00, phase}, 8'h00);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    check("reset w", working_reg, 8'h00);
    check("reset zero", {7'h00, zero_flag}, 8'h00);
    t_bclr(1'b0, 1'b0);
    t_and_literal_op;
    t_and_file_op;
    t_bclr(1'b1, 1'b1);
    t_abort;
    summarize;
  end

  initial begin
    #20000;
    num_errors++;
    summarize;
  end
endmodule
